// ==== hw/bpm_pkg.sv ====
// Purpose: shared constants and carriers for the backup power monitor
// Assumes: comparator and level results arrive as asynchronous digital levels
// Notes:   time stamp is a packed calendar snapshot supplied by the calendar block
package bpm_pkg;

  // ==========================================================================
  // widths and reset values
  localparam int         BPM_STAMP_W     = 40;
  localparam int         BPM_LEVEL_W     = 3;
  localparam logic [2:0] BPM_LEVEL_COUNT = 3'h6;
  localparam logic       BPM_BACKUP_RST  = 1'b0;
  localparam logic       BPM_LOSS_RST    = 1'b1;

  // ==========================================================================
  // supply comparator results
  typedef struct packed {
    logic below_backup;      // main < backup - hysteresis
    logic below_trip;        // main < trip
    logic above_backup;      // main > backup + hysteresis
    logic above_trip;        // main > trip + trip hysteresis
  } bpm_cmp_s;

  // battery level comparators
  typedef struct packed {
    logic below_85;
    logic below_75;
  } bpm_bat_s;

  typedef struct packed {
    logic power_loss_flag;
    logic brownout_flag;
    logic battery_low_first_flag;
    logic battery_low_second_flag;
  } bpm_status_s;

  typedef enum logic [1:0] {
    BPM_NORMAL = 2'b01,
    BPM_BACKUP = 2'b10
  } bpm_mode_e;

endpackage : bpm_pkg

// ==== hw/bpm_monitor.sv ====
// Purpose: supply switchover, bus gating, time stamps and power status flags
// Assumes: i_clock is the timekeeping clock; analog comparators sit outside
// Notes:   flags are plain outputs; the host clear strobes come from the bus block
`timescale 1ns/100ps
module bpm_monitor
  import bpm_pkg::*;
(
  // clock and reset
  input  wire logic                   i_clock,
  input  wire logic                   i_rst_n,
  // analog results, asynchronous
  input  wire bpm_cmp_s               i_cmp,
  input  wire bpm_bat_s               i_bat,
  input  wire logic [BPM_LEVEL_COUNT-1:0] i_brownout_below,
  // configuration and host strobes, same clock
  input  wire logic [BPM_LEVEL_W-1:0] i_brownout_sel,
  input  wire logic                   i_temp_sense_enable,
  input  wire logic                   i_backup_temp_sense_enable,
  input  wire logic                   i_stamp_clear,
  input  wire logic                   i_power_loss_clear,
  input  wire logic                   i_pin_backup_disable,
  input  wire logic [BPM_STAMP_W-1:0] i_time_now,
  // status and control outputs
  output logic                        o_backup_mode,
  output logic                        o_bus_enable,
  output logic                        o_comp_enable,
  output logic                        o_pin_enable,
  output logic [BPM_STAMP_W-1:0]      o_powerdown_stamp,
  output logic [BPM_STAMP_W-1:0]      o_powerup_stamp,
  output bpm_status_s                 o_status
);

  // ==========================================================================
  // reset release
  logic [1:0] rst_sync_r;
  logic       rst_n;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) rst_sync_r <= 2'b00;
    else          rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // ==========================================================================
  // input synchronisers
  localparam int SW = 4 + 2 + BPM_LEVEL_COUNT;
  logic [SW-1:0] in_s1_r, in_s2_r;
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_r <= '0;
      in_s2_r <= '0;
    end else begin
      in_s1_r <= {i_cmp, i_bat, i_brownout_below};
      in_s2_r <= in_s1_r;
    end
  end
  bpm_cmp_s                   cmp;
  bpm_bat_s                   bat;
  logic [BPM_LEVEL_COUNT-1:0] bo_below;
  assign {cmp, bat, bo_below} = in_s2_r;

  // ==========================================================================
  // next-state logic
  bpm_mode_e             mode_r, mode_nxt;
  logic                  bus_en_r, bus_en_nxt;
  logic                  comp_en_r, comp_en_nxt;
  logic                  pin_en_r, pin_en_nxt;
  logic [BPM_STAMP_W-1:0] pd_r, pd_nxt, pu_r, pu_nxt;
  logic                  pd_valid_r, pd_valid_nxt;
  bpm_status_s           st_r, st_nxt;
  logic                  meas_r, meas_nxt;
  logic                  enter, leave, bo_hit;

  always_comb begin
    enter        = (mode_r == BPM_NORMAL) && cmp.below_backup && cmp.below_trip;
    leave        = (mode_r == BPM_BACKUP) && (cmp.above_backup || cmp.above_trip);
    bo_hit       = (i_brownout_sel < BPM_LEVEL_COUNT) ? bo_below[i_brownout_sel] : 1'b0;
    mode_nxt     = mode_r;
    pd_nxt       = pd_r;
    pu_nxt       = pu_r;
    pd_valid_nxt = pd_valid_r;
    st_nxt       = st_r;
    meas_nxt     = meas_r;
    if (enter) mode_nxt = BPM_BACKUP;
    else if (leave) mode_nxt = BPM_NORMAL;
    // clear first so a same-cycle capture wins
    if (i_stamp_clear) begin
      pd_nxt       = '0;
      pu_nxt       = '0;
      pd_valid_nxt = 1'b0;
    end
    if (enter && !pd_valid_r) begin
      pd_nxt       = i_time_now;
      pd_valid_nxt = 1'b1;
    end
    if (leave) pu_nxt = i_time_now;
    if (i_power_loss_clear) st_nxt.power_loss_flag = 1'b0;
    st_nxt.brownout_flag = bo_hit;
    // battery monitor only measures in normal mode on request
    if (mode_nxt == BPM_BACKUP) meas_nxt = 1'b0;
    else if (i_temp_sense_enable) meas_nxt = 1'b1;
    if (meas_r && mode_r == BPM_NORMAL) begin
      st_nxt.battery_low_first_flag  = bat.below_85 | bat.below_75;
      st_nxt.battery_low_second_flag = bat.below_75;
    end
    bus_en_nxt  = (mode_nxt == BPM_NORMAL);
    comp_en_nxt = (mode_nxt == BPM_NORMAL) || i_backup_temp_sense_enable;
    pin_en_nxt  = (mode_nxt == BPM_NORMAL) || !i_pin_backup_disable;
  end

  // ==========================================================================
  // registers; power loss flag comes up set since a reset is a cold start
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_r     <= BPM_NORMAL;
      bus_en_r   <= 1'b0;
      comp_en_r  <= 1'b0;
      pin_en_r   <= 1'b0;
      pd_r       <= '0;
      pu_r       <= '0;
      pd_valid_r <= 1'b0;
      st_r       <= '{power_loss_flag: BPM_LOSS_RST, default: 1'b0};
      meas_r     <= 1'b0;
    end else begin
      mode_r     <= mode_nxt;
      bus_en_r   <= bus_en_nxt;
      comp_en_r  <= comp_en_nxt;
      pin_en_r   <= pin_en_nxt;
      pd_r       <= pd_nxt;
      pu_r       <= pu_nxt;
      pd_valid_r <= pd_valid_nxt;
      st_r       <= st_nxt;
      meas_r     <= meas_nxt;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) o_backup_mode <= BPM_BACKUP_RST;
    else        o_backup_mode <= (mode_nxt == BPM_BACKUP);
  end
  assign o_bus_enable      = bus_en_r;
  assign o_comp_enable     = comp_en_r;
  assign o_pin_enable      = pin_en_r;
  assign o_powerdown_stamp = pd_r;
  assign o_powerup_stamp   = pu_r;
  assign o_status          = st_r;

  // ==========================================================================
  // checks
  sequence s_enter;
    cmp.below_backup && cmp.below_trip && (mode_r == BPM_NORMAL);
  endsequence
  property p_enter;
    @(posedge i_clock) disable iff (!rst_n) s_enter |=> (mode_r == BPM_BACKUP);
  endproperty
  a_enter: assert property (p_enter) else $error("backup not entered");
  property p_no_enter;
    @(posedge i_clock) disable iff (!rst_n)
      (mode_r == BPM_NORMAL) && !cmp.below_trip |=> (mode_r == BPM_NORMAL);
  endproperty
  a_no_enter: assert property (p_no_enter) else $error("backup entered above trip");
  property p_leave;
    @(posedge i_clock) disable iff (!rst_n)
      (mode_r == BPM_BACKUP) && cmp.above_trip |=> (mode_r == BPM_NORMAL);
  endproperty
  a_leave: assert property (p_leave) else $error("normal not restored");
  property p_bus;
    @(posedge i_clock) disable iff (!rst_n) (mode_r == BPM_BACKUP) |-> !o_bus_enable;
  endproperty
  a_bus: assert property (p_bus) else $error("bus enabled in backup");
  property p_stamp_hold;
    @(posedge i_clock) disable iff (!rst_n)
      pd_valid_r && !i_stamp_clear |=> (pd_r == $past(pd_r));
  endproperty
  a_stamp_hold: assert property (p_stamp_hold) else $error("power-down stamp moved");
  property p_stamp_clear;
    @(posedge i_clock) disable iff (!rst_n)
      i_stamp_clear && !enter && !leave |=> (pd_r == '0) && (pu_r == '0);
  endproperty
  a_stamp_clear: assert property (p_stamp_clear) else $error("stamps not cleared");
  property p_comp;
    @(posedge i_clock) disable iff (!rst_n)
      (mode_r == BPM_BACKUP) && !$past(i_backup_temp_sense_enable) |-> !o_comp_enable;
  endproperty
  a_comp: assert property (p_comp) else $error("compensation ran in backup");
  property p_bat;
    @(posedge i_clock) disable iff (!rst_n)
      o_status.battery_low_second_flag |-> o_status.battery_low_first_flag;
  endproperty
  a_bat: assert property (p_bat) else $error("second battery flag without first");
  property p_pin;
    @(posedge i_clock) disable iff (!rst_n)
      (mode_r == BPM_BACKUP) && $past(i_pin_backup_disable) |-> !o_pin_enable;
  endproperty
  a_pin: assert property (p_pin) else $error("pin left active in backup");
  // sampled rst_n in the antecedent skips the edge at which reset lets go
  property p_bus_normal;
    @(posedge i_clock) disable iff (!rst_n)
      rst_n && (mode_r == BPM_NORMAL) && (mode_nxt == BPM_NORMAL) |=> o_bus_enable;
  endproperty
  a_bus_normal: assert property (p_bus_normal) else $error("bus lost in normal mode");
  property p_loss_hold;
    @(posedge i_clock) disable iff (!rst_n)
      o_status.power_loss_flag && !i_power_loss_clear |=> o_status.power_loss_flag;
  endproperty
  a_loss_hold: assert property (p_loss_hold) else $error("power loss flag dropped");
  property p_bat_idle;
    @(posedge i_clock) disable iff (!rst_n)
      (mode_r == BPM_BACKUP) |=> $stable(o_status.battery_low_first_flag);
  endproperty
  a_bat_idle: assert property (p_bat_idle) else $error("battery flag moved in backup");
  property p_no_level;
    @(posedge i_clock) disable iff (!rst_n)
      (i_brownout_sel >= BPM_LEVEL_COUNT) |=> !o_status.brownout_flag;
  endproperty
  a_no_level: assert property (p_no_level) else $error("brownout on unused level");

endmodule : bpm_monitor

// ==== dv/bpm_host_model.sv ====
// Purpose: host side of the serial bus, issuing one-cycle register writes
// Assumes: bit 2 stamp clear, bit 1 temp sense enable, bit 0 power loss clear
// Notes:   writes are lost while the device has its bus switched off
`timescale 1ns/100ps
module bpm_host_model (
  // clock and bus state
  input  wire logic       i_clock,
  input  wire logic       i_bus_enable,
  // requested writes
  input  wire logic [2:0] i_req,
  output logic      [2:0] o_write = 3'h0
);
  // ==========================================================================
  // a dead bus swallows the write, as a real transfer would get no answer
  always @(posedge i_clock) begin
    o_write <= i_req & {3{i_bus_enable}};
  end
endmodule : bpm_host_model

// ==== dv/bpm_monitor_tb_top.sv ====
// Purpose: self-checking bench for the backup power monitor
// Assumes: host writes pass through the host model
// Notes:   waits of six cycles cover the three-edge mode latency
`timescale 1ns/100ps
module bpm_monitor_tb_top;
  import bpm_pkg::*;
  typedef struct packed {
    bpm_cmp_s         cmp;
    logic [39:0]      t;
    logic             bk;
    logic [39:0]      pd;
    logic [39:0]      pu;
  } bpm_row_s;
  logic clk = 1'b0, rst_n = 1'b0, bte = 1'b0, pdis = 1'b0;
  bpm_cmp_s cmp = 4'h0;
  bpm_bat_s bat = 2'h0;
  logic [5:0] below = 6'h00;
  logic [2:0] sel = 3'h7, req = 3'h0, wr;
  logic [39:0] now = 40'h0, pd, pu;
  logic bk, bus, comp, pin;
  bpm_status_s st;
  int num_errors = 0, total_checks = 0;
  bpm_row_s rows [6] = '{'{4'h8, 40'h1, 1'b0, 40'h0, 40'h0}, '{4'h4, 40'h2, 1'b0, 40'h0, 40'h0},
    '{4'hc, 40'h3, 1'b1, 40'h3, 40'h0}, '{4'h2, 40'h4, 1'b0, 40'h3, 40'h4},
    '{4'hc, 40'h5, 1'b1, 40'h3, 40'h4}, '{4'h1, 40'h6, 1'b0, 40'h3, 40'h6}};
  always #2 clk = ~clk;
  bpm_monitor uut (.i_clock(clk), .i_rst_n(rst_n), .i_cmp(cmp), .i_bat(bat),
    .i_brownout_below(below), .i_brownout_sel(sel), .i_temp_sense_enable(wr[1]),
    .i_backup_temp_sense_enable(bte), .i_stamp_clear(wr[2]), .i_power_loss_clear(wr[0]),
    .i_pin_backup_disable(pdis), .i_time_now(now), .o_backup_mode(bk), .o_bus_enable(bus),
    .o_comp_enable(comp), .o_pin_enable(pin), .o_powerdown_stamp(pd),
    .o_powerup_stamp(pu), .o_status(st));
  bpm_host_model host_m (.i_clock(clk), .i_bus_enable(bus), .i_req(req), .o_write(wr));
  // ==========================================================================
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task automatic check(input string nm, input logic [39:0] exp, input logic [39:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic host(input logic [2:0] c);
    req <= c;
    step(1);
    req <= 3'h0;
    step(4);
  endtask : host
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // ==========================================================================
  initial begin
    step(12);
    rst_n <= 1'b1;
    step(5);
    check("power_loss_flag", 1'b1, st.power_loss_flag);
    foreach (rows[k]) begin
      cmp <= rows[k].cmp;
      now <= rows[k].t;
      step(6);
      check("backup_mode", rows[k].bk, bk);
      check("bus_enable", !rows[k].bk, bus);
      check("pin_enable", 1'b1, pin);
      check("powerdown_stamp", rows[k].pd, pd);
      check("powerup_stamp", rows[k].pu, pu);
    end
    host(3'h4);
    check("powerdown_stamp", 40'h0, pd);
    check("powerup_stamp", 40'h0, pu);
    below <= 6'h04;
    for (int s = 0; s < 8; s++) begin
      sel <= 3'(s);
      step(6);
      check("brownout_flag", s == 2, st.brownout_flag);
      check("bus_enable", 1'b1, bus);
    end
    bat <= 2'b10;
    host(3'h2);
    check("low_first", 1'b1, st.battery_low_first_flag);
    check("low_second", 1'b0, st.battery_low_second_flag);
    bat <= 2'b11;
    host(3'h2);
    check("low_second", 1'b1, st.battery_low_second_flag);
    bte <= 1'b1;
    pdis <= 1'b1;
    cmp <= 4'hc;
    step(6);
    check("comp_enable", 1'b1, comp);
    check("pin_enable", 1'b0, pin);
    check("powerdown_stamp", 40'h6, pd);
    check("bus_enable", 1'b0, bus);
    bte <= 1'b0;
    host(3'h1);
    check("comp_enable", 1'b0, comp);
    check("power_loss_flag", 1'b1, st.power_loss_flag);
    cmp <= 4'h2;
    bat <= 2'b00;
    step(6);
    // no measurement yet after the return, so the old levels remain
    check("low_first", 1'b1, st.battery_low_first_flag);
    check("powerup_stamp", 40'h6, pu);
    check("pin_enable", 1'b1, pin);
    host(3'h3);
    check("low_first", 1'b0, st.battery_low_first_flag);
    check("low_second", 1'b0, st.battery_low_second_flag);
    check("power_loss_flag", 1'b0, st.power_loss_flag);
    rst_n <= 1'b0;
    step(2);
    check("power_loss_flag", 1'b1, st.power_loss_flag);
    check("backup_mode", 1'b0, bk);
    rst_n <= 1'b1;
    step(5);
    check("bus_enable", 1'b1, bus);
    check("powerdown_stamp", 40'h0, pd);
    wrap_up();
  end
  // tests need about 150 cycles
  initial begin
    step(2000);
    num_errors++;
    wrap_up();
  end
endmodule : bpm_monitor_tb_top
